//--- hdl/hbc_bridge.sv
// Purpose: BAR0 register bridge to settings, board bus and FPGA loading
// Assumes: One target request at a time; inputs synchronous to ref_clk_in
// Notes:   BAR1-5 requests are passed on to the first user FPGA
`timescale 1ns/1ns
`include "hbc_cfg.svh"
module hbc_bridge #(
   parameter int TMO_W = 16
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic bridge_configured_in,
   input wire logic req_valid_in,
   input wire hbc_pkg::hbc_req_t req_in,
   output logic req_accept_out,
   output logic rsp_valid_out,
   output logic [31:0] rsp_data_out,
   output logic user_req_valid_out,
   output hbc_pkg::hbc_req_t user_req_out,
   input wire logic user_accept_in,
   input wire logic user_rsp_valid_in,
   input wire logic [31:0] user_rsp_data_in,
   output logic set_wr_valid_out,
   output hbc_pkg::hbc_set_wr_t set_wr_out,
   output logic set_rd_strobe_out,
   output logic [15:0] set_rd_addr_out,
   input wire logic [7:0] set_rd_data_in,
   output logic bb_req_valid_out,
   output hbc_pkg::hbc_bb_req_t bb_req_out,
   input wire logic bb_ack_in,
   input wire logic [31:0] bb_rdata_in,
   input wire logic bb_usb_busy_in,
   output logic [1:0] fpga_program_clear_n_out,
   input wire logic [1:0] fpga_init_ready_n_in,
   input wire logic [1:0] fpga_done_in,
   output logic [1:0] pcp_target_out,
   output logic pcp_valid_out,
   output logic [7:0] pcp_data_out,
   input wire logic pcp_ready_in
);
   import hbc_pkg::*;

   if (TMO_W < 10 || TMO_W > 32) begin : g_chk
      $error("hbc_bridge: TMO_W must hold the default timeout");
   end

   hbc_state_t state, next_state;
   hbc_req_t user_req, next_user_req;
   hbc_set_wr_t set_wr;
   logic [31:0] bb_addr, bb_wdata, rsp_data, next_rsp_data;
   logic addr_flag, data_flag, bb_op_write, next_bb_op_write;
   logic rsp_valid, next_rsp_valid, set_wr_valid, set_rd_strobe;
   logic [15:0] set_rd_addr;
   logic [4:0] sel_code, next_sel_code;
   logic prog_act, next_prog_act;
   logic [1:0] prog_n, target;
   logic [TMO_W-1:0] tmo_limit;
   logic tmo_expired, fifo_in_ready, fifo_out_valid;
   logic [7:0] fifo_out_data;

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   wire idle = state == S_IDLE;
   wire [15:0] off = req_in.addr[15:0];
   wire is_bar0 = req_in.bar == `HBC_BAR0;
   wire hit_sel = is_bar0 && off == `HBC_OFF_SEL;
   wire hit_stream = is_bar0 && off == `HBC_OFF_STREAM;
   wire hit_bbaddr = is_bar0 && off == `HBC_OFF_BB_ADDR;
   wire hit_bbwd = is_bar0 && off == `HBC_OFF_BB_WDATA;
   wire hit_bbrd = is_bar0 && off == `HBC_OFF_BB_RDATA;
   wire hit_cfgw = is_bar0 && off == `HBC_OFF_SET_WR;
   wire hit_cfgrd = is_bar0 && off == `HBC_OFF_SET_RD;
   wire hit_ctrl = is_bar0 && off == `HBC_OFF_BB_CTRL;
   wire stall = req_in.write && hit_stream && !fifo_in_ready;
   assign req_accept_out = req_valid_in && idle && !stall;
   wire wr = req_accept_out && req_in.write && bridge_configured_in;
   wire rd = req_accept_out && !req_in.write;
   wire rd_ok = rd && bridge_configured_in;
   wire [4:0] wcode = req_in.wdata[4:0];
   wire cfg_wr_ok = wr && hit_cfgw && req_in.wdata[31:16] >= `HBC_SET_WR_LO;
   wire go_user = req_accept_out && bridge_configured_in && !is_bar0;
   wire bb_addr_set = addr_flag || (wr && hit_bbaddr);
   wire bb_data_set = data_flag || (wr && hit_bbwd);
   wire launch_wr = wr && (hit_bbaddr || hit_bbwd) && bb_addr_set && bb_data_set;
   wire launch_rd = rd_ok && hit_bbrd && !bb_usb_busy_in;
   wire go_cfg_rd = rd_ok && hit_cfgrd;
   wire imm_rd = rd && !(launch_rd || go_user || go_cfg_rd);

   // ----------------------------------------
   // Selection status and immediate read word
   // ----------------------------------------
   wire sel_valid = sel_code == `HBC_SEL_A || sel_code == `HBC_SEL_B;
   wire sel_idx = sel_code == `HBC_SEL_B;
   wire init_sel = sel_valid ? fpga_init_ready_n_in[sel_idx] : 1'b1;
   wire done_sel = sel_valid && fpga_done_in[sel_idx];
   // Seven bits: init, done, code with program state in bit 3
   wire [31:0] sel_word = {25'h0, init_sel, done_sel, sel_code[4], prog_act,
      sel_code[2:0]};
   wire [31:0] imm_word = !bridge_configured_in ? `HBC_WORD_UNCLAIMED :
      hit_sel ? sel_word :
      hit_bbaddr ? bb_addr :
      hit_ctrl ? 32'(tmo_limit) :
      hit_bbrd ? `HBC_WORD_USB : 32'h0;

   // ----------------------------------------
   // Transaction sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data;
      next_user_req = user_req;
      next_bb_op_write = bb_op_write;
      case (state)
         S_IDLE: begin
            if (imm_rd) begin
               next_rsp_valid = 1'b1;
               next_rsp_data = imm_word;
            end
            if (go_user) begin
               next_state = S_USER;
               next_user_req = req_in;
            end else if (launch_wr || launch_rd) begin
               next_state = S_BB;
               next_bb_op_write = launch_wr;
            end else if (go_cfg_rd) begin
               next_state = S_CFG_RD;
            end
         end
         S_USER: begin
            if (user_accept_in) begin
               if (user_req.write) begin
                  next_state = S_IDLE;
               end else if (user_rsp_valid_in) begin
                  next_state = S_IDLE;
                  next_rsp_valid = 1'b1;
                  next_rsp_data = user_rsp_data_in;
               end else begin
                  next_state = S_USER_RD;
               end
            end
         end
         S_USER_RD: begin
            if (user_rsp_valid_in) begin
               next_state = S_IDLE;
               next_rsp_valid = 1'b1;
               next_rsp_data = user_rsp_data_in;
            end
         end
         S_BB: begin
            if (bb_ack_in || tmo_expired) begin
               next_state = S_IDLE;
               next_rsp_valid = !bb_op_write;
               next_rsp_data = bb_ack_in ? bb_rdata_in : `HBC_WORD_NORESP;
            end
         end
         S_CFG_RD: begin
            next_state = S_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp_data = {24'h0, set_rd_data_in};
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // FPGA selection and program pins
   // ----------------------------------------
   always_comb begin
      next_sel_code = sel_code;
      next_prog_act = prog_act;
      if (wr && hit_sel) begin
         if (wcode == `HBC_SEL_NONE) begin
            next_sel_code = `HBC_SEL_NONE;
            next_prog_act = 1'b0;
         end else if (wcode == `HBC_SEL_A || wcode == `HBC_SEL_B) begin
            if (wcode == sel_code && prog_act) begin
               next_prog_act = 1'b0;
            end else begin
               next_sel_code = wcode;
               next_prog_act = 1'b1;
            end
         end
      end
   end

   wire [1:0] next_target = {next_sel_code == `HBC_SEL_B, next_sel_code == `HBC_SEL_A};

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sel_code <= `HBC_SEL_NONE;
         prog_act <= 1'b0;
         target <= 2'h0;
         prog_n <= 2'h3;
      end else begin
         sel_code <= next_sel_code;
         prog_act <= next_prog_act;
         target <= next_target;
         prog_n <= ~(next_target & {2{next_prog_act}});
      end
   end

   // ----------------------------------------
   // Sequencer and response registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= S_IDLE;
         rsp_valid <= 1'b0;
         rsp_data <= 32'h0;
         user_req <= '0;
         bb_op_write <= 1'b0;
      end else begin
         state <= next_state;
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         user_req <= next_user_req;
         bb_op_write <= next_bb_op_write;
      end
   end

   // ----------------------------------------
   // Board bus and setting registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         addr_flag <= 1'b0;
         data_flag <= 1'b0;
         bb_addr <= 32'h0;
         bb_wdata <= 32'h0;
         tmo_limit <= TMO_W'(`HBC_TIMEOUT_CYC);
         set_wr_valid <= 1'b0;
         set_wr <= '0;
         set_rd_strobe <= 1'b0;
         set_rd_addr <= 16'h0;
      end else begin
         addr_flag <= !launch_wr && bb_addr_set;
         data_flag <= !launch_wr && bb_data_set;
         bb_addr <= (wr && hit_bbaddr) ? req_in.wdata : bb_addr;
         bb_wdata <= (wr && hit_bbwd) ? req_in.wdata : bb_wdata;
         tmo_limit <= (wr && hit_ctrl) ? req_in.wdata[TMO_W-1:0] : tmo_limit;
         set_wr_valid <= cfg_wr_ok;
         set_wr <= cfg_wr_ok ? {req_in.wdata[31:16], req_in.wdata[7:0]} : set_wr;
         set_rd_strobe <= go_cfg_rd;
         set_rd_addr <= go_cfg_rd ? {`HBC_SET_RD_HI, req_in.addr[23:16]} : set_rd_addr;
      end
   end

   // ----------------------------------------
   // Configuration stream path, board bus timer and outputs
   // ----------------------------------------
   hbc_fifo #(.W(8), .D(16)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(wr && hit_stream),
      .in_ready_out(fifo_in_ready),
      .in_data_in(req_in.wdata[7:0]),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(pcp_ready_in && sel_valid),
      .out_data_out(fifo_out_data)
   );

   hbc_timer #(.W(TMO_W)) u_tmo (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .run_in(state == S_BB),
      .limit_in(tmo_limit),
      .expired_out(tmo_expired)
   );

   assign pcp_valid_out = fifo_out_valid && sel_valid;
   assign pcp_data_out = fifo_out_data;
   assign pcp_target_out = target;
   assign fpga_program_clear_n_out = prog_n;
   assign rsp_valid_out = rsp_valid;
   assign rsp_data_out = rsp_data;
   assign user_req_valid_out = state == S_USER;
   assign user_req_out = user_req;
   assign set_wr_valid_out = set_wr_valid;
   assign set_wr_out = set_wr;
   assign set_rd_strobe_out = set_rd_strobe;
   assign set_rd_addr_out = set_rd_addr;
   assign bb_req_valid_out = state == S_BB;
   assign bb_req_out = '{write: bb_op_write, addr: bb_addr, wdata: bb_wdata};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_set_wr;
      cfg_wr_ok |=> set_wr_valid_out && set_wr_out.data == $past(req_in.wdata[7:0])
         && set_wr_out.addr == $past(req_in.wdata[31:16]);
   endproperty
   a_set_wr: assert property (p_set_wr) else $error("setting write lost");
   property p_set_range;
      set_wr_valid_out |-> set_wr_out.addr >= `HBC_SET_WR_LO;
   endproperty
   a_set_range: assert property (p_set_range) else $error("setting address low");
   property p_set_rd;
      go_cfg_rd |=> set_rd_strobe_out && set_rd_addr_out[15:8] == `HBC_SET_RD_HI
         ##1 rsp_valid_out && rsp_data_out == {24'h0, $past(set_rd_data_in)};
   endproperty
   a_set_rd: assert property (p_set_rd) else $error("setting read wrong");
   property p_bb_wr;
      launch_wr |=> bb_req_valid_out && bb_req_out.write && !addr_flag && !data_flag;
   endproperty
   a_bb_wr: assert property (p_bb_wr) else $error("board write not issued");
   property p_noresp;
      state == S_BB && tmo_expired && !bb_ack_in && !bb_op_write
         |=> rsp_valid_out && rsp_data_out == `HBC_WORD_NORESP;
   endproperty
   a_noresp: assert property (p_noresp) else $error("timeout word wrong");
   property p_usb;
      rd_ok && hit_bbrd && bb_usb_busy_in |=> rsp_valid_out && rsp_data_out == `HBC_WORD_USB;
   endproperty
   a_usb: assert property (p_usb) else $error("busy word wrong");
   property p_deselect;
      wr && hit_sel && wcode == `HBC_SEL_NONE
         |=> pcp_target_out == 2'h0 && fpga_program_clear_n_out == 2'h3;
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect failed");
   property p_prog;
      wr && hit_sel && wcode == `HBC_SEL_A && sel_code != `HBC_SEL_A
         |=> fpga_program_clear_n_out == 2'h2 [*2];
   endproperty
   a_prog: assert property (p_prog) else $error("program pin wrong");
   property p_init;
      imm_rd && bridge_configured_in && hit_sel |=> rsp_data_out[6] == $past(init_sel);
   endproperty
   a_init: assert property (p_init) else $error("init bit wrong");
   property p_unclaimed;
      rd && !bridge_configured_in |=> rsp_valid_out && rsp_data_out == `HBC_WORD_UNCLAIMED;
   endproperty
   a_unclaimed: assert property (p_unclaimed) else $error("unclaimed word wrong");
   property p_user;
      go_user |=> user_req_valid_out && user_req_out == $past(req_in);
   endproperty
   a_user: assert property (p_user) else $error("user request lost");

   c_bb_rd: cover property (launch_rd ##[1:20] bb_ack_in);
   c_stream: cover property (pcp_valid_out && pcp_ready_in);
   c_full: cover property (stall && req_valid_in);
   c_user_rd: cover property (go_user && !req_in.write ##[1:10] user_rsp_valid_in);
endmodule

//--- hdl/hbc_cfg.svh
// Purpose: Offsets, codes and timing constants of the host bridge
// Assumes: 10 MHz reference clock
// Notes:   Offsets are BAR0 byte offsets, bits 15-0 of the address
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH
`define HBC_BAR0 3'h0
`define HBC_OFF_SEL 16'h0208
`define HBC_OFF_STREAM 16'h0210
`define HBC_OFF_BB_ADDR 16'h0240
`define HBC_OFF_BB_WDATA 16'h0248
`define HBC_OFF_BB_RDATA 16'h0250
`define HBC_OFF_SET_WR 16'h0258
`define HBC_OFF_SET_RD 16'h0260
`define HBC_OFF_BB_CTRL 16'h0270
`define HBC_SET_WR_LO 16'hDF00
`define HBC_SET_RD_HI 8'hDF
`define HBC_SEL_NONE 5'h10
`define HBC_SEL_A 5'h11
`define HBC_SEL_B 5'h12
`define HBC_WORD_NORESP 32'hBBBBBBBB
`define HBC_WORD_USB 32'h01234567
`define HBC_WORD_UNCLAIMED 32'hFFFFFFFF
`define HBC_CLK_NS 100
`define HBC_TIMEOUT_NS 100000
`define HBC_TIMEOUT_CYC (`HBC_TIMEOUT_NS / `HBC_CLK_NS)
`endif

//--- hdl/hbc_pkg.sv
// Purpose: Types shared by the host bridge files
// Assumes: Nothing
// Notes:   Carriers are packed structs
package hbc_pkg;
   typedef struct packed {
      logic write;
      logic [2:0] bar;
      logic [23:0] addr;
      logic [31:0] wdata;
   } hbc_req_t;
   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hbc_bb_req_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } hbc_set_wr_t;
   typedef enum logic [2:0] {S_IDLE, S_USER, S_USER_RD, S_BB, S_CFG_RD} hbc_state_t;
endpackage

//--- hdl/hbc_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Read data comes straight from the storage flops
`timescale 1ns/1ns
module hbc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(D);
   if (D < 2 || (1 << AW) != D || W < 1) begin : g_chk
      $error("hbc_fifo: depth must be a power of two of at least 2");
   end
   logic [W-1:0] mem [D];
   logic [AW:0] wr_ptr, rd_ptr;
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   assign out_valid_out = wr_ptr != rd_ptr;
   assign in_ready_out = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_data_out = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= rd_ptr + (AW+1)'(pop);
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end
endmodule

//--- hdl/hbc_timer.sv
// Purpose: Wait counter that expires at a programmable limit
// Assumes: Limit is stable while running
// Notes:   Cleared whenever run is low
`timescale 1ns/1ns
module hbc_timer #(
   parameter int W = 16
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic run_in,
   input wire logic [W-1:0] limit_in,
   output logic expired_out
);
   logic [W-1:0] count;
   assign expired_out = run_in && count >= limit_in;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count <= '0;
      end else if (!run_in) begin
         count <= '0;
      end else if (!expired_out) begin
         count <= count + W'(1);
      end
   end
endmodule

//--- verif/hbc_far_end.sv
// Purpose: Far-side model: board bus, FPGA pins, config port, user FPGA
// Assumes: Driven by the bridge outputs on ref_clk_in
// Notes:   Board address bit 31 set means no responder; bit 4 set is slow
`timescale 1ns/1ns
module hbc_far_end (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic stall_in,
   input wire logic user_req_valid_in,
   input wire hbc_pkg::hbc_req_t user_req_in,
   output logic user_accept_out,
   output logic user_rsp_valid_out,
   output logic [31:0] user_rsp_data_out,
   input wire logic set_rd_strobe_in,
   input wire logic [15:0] set_rd_addr_in,
   output logic [7:0] set_rd_data_out,
   input wire logic bb_req_valid_in,
   input wire hbc_pkg::hbc_bb_req_t bb_req_in,
   output logic bb_ack_out,
   output logic [31:0] bb_rdata_out,
   input wire logic [1:0] clear_n_in,
   output logic [1:0] ready_n_out,
   output logic [1:0] done_out,
   input wire logic [1:0] pcp_target_in,
   input wire logic pcp_valid_in,
   input wire logic [7:0] pcp_data_in,
   output logic pcp_ready_out
);
   import hbc_pkg::*;
   logic [7:0] cyc;
   logic [2:0] bcnt, nb0, nb1;
   logic ucnt;
   logic pop;
   int n_wr = 0;
   logic [31:0] bb_wr_addr, bb_wr_data;
   hbc_req_t user_last;
   logic [9:0] got[$];
   // ----------------------------------------
   // Answers; idle lines keep changing
   // ----------------------------------------
   assign set_rd_data_out = set_rd_strobe_in ? ~set_rd_addr_in[7:0] : cyc;
   assign bb_ack_out = bb_req_valid_in && !bb_req_in.addr[31] &&
      bcnt == (bb_req_in.addr[4] ? 3'h3 : 3'h0);
   assign bb_rdata_out = bb_ack_out ? bb_req_in.addr ^ 32'h5A5A0000 : {4{cyc}};
   assign user_accept_out = user_req_valid_in && ucnt;
   assign user_rsp_valid_out = user_accept_out && !user_req_in.write;
   assign user_rsp_data_out = user_rsp_valid_out ? {8'hC0, user_req_in.addr} : {4{~cyc}};
   assign pcp_ready_out = !stall_in && cyc[0];
   assign pop = pcp_valid_in && pcp_ready_out;
   assign done_out = {nb1[2], nb0[2]};
   // ----------------------------------------
   // Pin state and recording
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cyc <= 8'h00;
         bcnt <= 3'h0;
         ucnt <= 1'b0;
         ready_n_out <= 2'b11;
         nb0 <= 3'h0;
         nb1 <= 3'h0;
      end else begin
         cyc <= cyc + 8'h01;
         bcnt <= bb_req_valid_in ? bcnt + 3'h1 : 3'h0;
         ucnt <= user_req_valid_in && !user_accept_out;
         ready_n_out <= clear_n_in;
         nb0 <= !clear_n_in[0] ? 3'h0 : (pop && pcp_target_in[0] && !nb0[2]) ? nb0 + 3'h1 : nb0;
         nb1 <= !clear_n_in[1] ? 3'h0 : (pop && pcp_target_in[1] && !nb1[2]) ? nb1 + 3'h1 : nb1;
      end
   end
   always @(posedge ref_clk_in) begin
      if (bb_ack_out && bb_req_in.write) begin
         n_wr++;
         bb_wr_addr = bb_req_in.addr;
         bb_wr_data = bb_req_in.wdata;
      end
      if (user_accept_out) user_last = user_req_in;
      if (pop) got.push_back({pcp_target_in, pcp_data_in});
   end
endmodule

//--- verif/tb_host_board_control_bridge.sv
// Purpose: Self-checking bench of the host board control bridge
// Assumes: Far-side model hbc_far_end
// Notes:   Board bus timeout is set to 5 cycles
`timescale 1ns/1ns
`include "hbc_cfg.svh"
module tb_host_board_control_bridge;
   import hbc_pkg::*;
   logic clk, rst_n, cfg_ok, req_valid, usb_busy, stall, req_accept, rsp_valid;
   logic uv, ua, urv, srs, bbv, bba, pv, pr, swv;
   logic [31:0] rsp_data, urd, bbr;
   logic [15:0] sra;
   logic [7:0] srd, pd;
   logic [1:0] fpga_program_clear_n, fpga_init_ready_n, done, tgt;
   hbc_req_t req, ureq;
   hbc_bb_req_t bbq;
   hbc_set_wr_t sw, last_set;
   logic [15:0] last_rd;
   int num_errors = 0, compares = 0, n_set = 0;
   hbc_bridge u_dut (.ref_clk_in(clk), .reset_n_in(rst_n), .bridge_configured_in(cfg_ok),
      .req_valid_in(req_valid), .req_in(req), .req_accept_out(req_accept),
      .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .user_req_valid_out(uv),
      .user_req_out(ureq), .user_accept_in(ua), .user_rsp_valid_in(urv),
      .user_rsp_data_in(urd), .set_wr_valid_out(swv), .set_wr_out(sw),
      .set_rd_strobe_out(srs), .set_rd_addr_out(sra), .set_rd_data_in(srd),
      .bb_req_valid_out(bbv), .bb_req_out(bbq), .bb_ack_in(bba), .bb_rdata_in(bbr),
      .bb_usb_busy_in(usb_busy), .fpga_program_clear_n_out(fpga_program_clear_n),
      .fpga_init_ready_n_in(fpga_init_ready_n), .fpga_done_in(done), .pcp_target_out(tgt),
      .pcp_valid_out(pv), .pcp_data_out(pd), .pcp_ready_in(pr));
   hbc_far_end u_far (.ref_clk_in(clk), .reset_n_in(rst_n), .stall_in(stall),
      .user_req_valid_in(uv), .user_req_in(ureq), .user_accept_out(ua),
      .user_rsp_valid_out(urv), .user_rsp_data_out(urd), .set_rd_strobe_in(srs),
      .set_rd_addr_in(sra), .set_rd_data_out(srd), .bb_req_valid_in(bbv), .bb_req_in(bbq),
      .bb_ack_out(bba), .bb_rdata_out(bbr), .clear_n_in(fpga_program_clear_n),
      .ready_n_out(fpga_init_ready_n), .done_out(done), .pcp_target_in(tgt),
      .pcp_valid_in(pv), .pcp_data_in(pd), .pcp_ready_out(pr));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [2:0] bar, input logic [23:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req = {wr, bar, a, d};
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (req_accept !== 1'b1 && n < 3000);
      if (req_accept !== 1'b1) num_errors++;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (!wr && rsp_valid !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (!wr && rsp_valid !== 1'b1) num_errors++;
      q = rsp_data;
   endtask
   always @(posedge clk) begin
      if (swv === 1'b1) begin
         n_set++;
         last_set = sw;
      end
      if (srs === 1'b1) last_rd = sra;
   end
   task automatic summarize;
      $display("compares=%0d errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_settings;
      logic [31:0] q;
      bus(1, 0, 24'h000258, 32'hDF12FF5A, q);
      @(posedge clk);
      #1;
      chk(n_set, 1);
      chk(32'(last_set), 32'h00DF125A);
      bus(1, 0, 24'h000258, 32'hDEFF0077, q);
      bus(1, 0, 24'h000258, 32'hFFFF0033, q);
      repeat (2) @(posedge clk);
      chk(n_set, 2);
      chk(32'(last_set), 32'h00FFFF33);
      bus(0, 0, 24'h340260, 0, q);
      chk(q, 32'h000000CB);
      chk(32'(last_rd), 32'h0000DF34);
      $display("test settings done");
   endtask
   task automatic t_board;
      logic [31:0] q;
      bus(1, 0, 24'h000270, 32'h5, q);
      bus(0, 0, 24'h000270, 0, q);
      chk(q, 32'h5);
      bus(1, 0, 24'h000240, 32'h10, q);
      bus(0, 0, 24'h000240, 0, q);
      chk(q, 32'h10);
      chk(u_far.n_wr, 0);
      bus(1, 0, 24'h000248, 32'hCAFE0001, q);
      repeat (8) @(posedge clk);
      chk(u_far.n_wr, 1);
      chk(u_far.bb_wr_addr, 32'h10);
      chk(u_far.bb_wr_data, 32'hCAFE0001);
      bus(0, 0, 24'h000250, 0, q);
      chk(q, 32'h5A5A0010);
      bus(1, 0, 24'h000240, 32'h20, q);
      bus(0, 0, 24'h000250, 0, q);
      chk(q, 32'h5A5A0020);
      chk(u_far.n_wr, 1);
      bus(1, 0, 24'h000240, 32'h80000000, q);
      bus(0, 0, 24'h000250, 0, q);
      chk(q, `HBC_WORD_NORESP);
      @(posedge clk);
      #1;
      usb_busy = 1'b1;
      bus(0, 0, 24'h000250, 0, q);
      chk(q, `HBC_WORD_USB);
      usb_busy = 1'b0;
      $display("test board bus done");
   endtask
   task automatic t_select;
      logic [31:0] q;
      bus(1, 0, 24'h000208, 32'h11, q);
      chk(32'(fpga_program_clear_n), 32'h2);
      chk(32'(tgt), 32'h1);
      bus(0, 0, 24'h000208, 0, q);
      chk(q, 32'h19);
      bus(1, 0, 24'h000208, 32'h11, q);
      chk(32'(fpga_program_clear_n), 32'h3);
      repeat (2) @(posedge clk);
      bus(0, 0, 24'h000208, 0, q);
      chk(q, 32'h51);
      bus(1, 0, 24'h000208, 32'h12, q);
      bus(1, 0, 24'h000208, 32'h13, q);
      chk(32'(fpga_program_clear_n), 32'h1);
      chk(32'(tgt), 32'h2);
      bus(1, 0, 24'h000208, 32'h10, q);
      chk(32'(fpga_program_clear_n), 32'h3);
      chk(32'(tgt), 32'h0);
      bus(0, 0, 24'h000208, 0, q);
      chk(q, 32'h50);
      $display("test select done");
   endtask
   task automatic t_stream;
      logic [31:0] q;
      u_far.got.delete();
      bus(1, 0, 24'h000208, 32'h11, q);
      bus(1, 0, 24'h000208, 32'h11, q);
      stall = 1'b1;
      for (int i = 0; i < 16; i++) bus(1, 0, 24'h000210, {24'hFFFFFF, 8'(i + 48)}, q);
      fork
         bus(1, 0, 24'h000210, 32'h000000EE, q);
         begin
            repeat (6) begin
               @(negedge clk);
               chk(32'(req_accept), 32'h0);
            end
            @(posedge clk);
            #1;
            stall = 1'b0;
         end
      join
      repeat (80) @(posedge clk);
      chk(u_far.got.size(), 17);
      for (int i = 0; i < 17; i++) begin
         chk(32'(u_far.got[i]), i < 16 ? 32'h130 + i : 32'h1EE);
      end
      bus(0, 0, 24'h000208, 0, q);
      chk(q, 32'h71);
      $display("test stream done");
   endtask
   task automatic t_user;
      logic [31:0] q;
      bus(1, 3'h1, 24'h001234, 32'h11223344, q);
      repeat (4) @(posedge clk);
      chk(u_far.user_last.wdata, 32'h11223344);
      chk(32'({u_far.user_last.write, u_far.user_last.bar, u_far.user_last.addr}),
         32'h9001234);
      bus(0, 3'h3, 24'h00ABCD, 0, q);
      chk(q, 32'hC000ABCD);
      $display("test user done");
   endtask
   task automatic t_unconfig;
      logic [31:0] q;
      @(posedge clk);
      #1;
      cfg_ok = 1'b0;
      bus(0, 0, 24'h000240, 0, q);
      chk(q, `HBC_WORD_UNCLAIMED);
      bus(0, 3'h2, 24'h000000, 0, q);
      chk(q, `HBC_WORD_UNCLAIMED);
      bus(1, 0, 24'h000258, 32'hDF000001, q);
      repeat (3) @(posedge clk);
      chk(n_set, 2);
      #1;
      cfg_ok = 1'b1;
      bus(0, 0, 24'h000300, 0, q);
      chk(q, 32'h0);
      $display("test unconfigured done");
   endtask
   // ----------------------------------------
   // Clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      cfg_ok = 1'b1;
      req_valid = 1'b0;
      req = '0;
      usb_busy = 1'b0;
      stall = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_settings;
      t_board;
      t_select;
      t_stream;
      t_user;
      t_unconfig;
      summarize;
   end
   initial begin
      #2000000;
      num_errors++;
      summarize;
   end
endmodule
